// ### logic/bpb_pkg.sv
// Notes on behaviour
// - Bank B bit0 picks PWM input one/two
// - Bank C bit0 picks PWM input one/two
// - Bit1 polarity: 0 active low, 1 high
// - Bits 6:2 enable PWM per zone 0-4
// - Bright bit0: 0 ambient, 1 bus control
// - Bright bit1: 0 exponential, 1 linear mapping
// - Bits 4:2 pick target 0-3, 1XX target 4
// - Pointer only counts under bus control
// - Brightness registers at 0x16, 0x18, 0x1a
// - PWM maps B, C at 0x14, 0x15
// - Bank A PWM map at 0x13, same layout
// - Each sink follows its assigned bank
package bpb_pkg;

  localparam int NUM_BANKS = 3;
  localparam int NUM_ZONES = 5;

  localparam logic [7:0] OFF_SINK_MAP  = 8'h10;
  localparam logic [7:0] OFF_PWM_MAP_A = 8'h13;
  localparam logic [7:0] OFF_PWM_MAP_B = 8'h14;
  localparam logic [7:0] OFF_PWM_MAP_C = 8'h15;
  localparam logic [7:0] OFF_BRI_CFG_A = 8'h16;
  localparam logic [7:0] OFF_BRI_CFG_B = 8'h18;
  localparam logic [7:0] OFF_BRI_CFG_C = 8'h1a;

  // PWM map fields
  localparam int PWM_SEL_BIT  = 0;
  localparam int PWM_POL_BIT  = 1;
  localparam int PWM_ZONE_LSB = 2;
  localparam logic [7:0] PWM_MAP_MASK  = 8'h7f;
  localparam logic [7:0] PWM_MAP_RESET = 8'h02;

  // Brightness config fields
  localparam int BRI_BUS_BIT  = 0;
  localparam int BRI_LIN_BIT  = 1;
  localparam int BRI_PTR_LSB  = 2;
  localparam int BRI_PTR_MSB  = 4;
  localparam logic [7:0] BRI_CFG_MASK  = 8'h1f;
  localparam logic [7:0] BRI_CFG_RESET = 8'h11;

  // Sink assignment: two bits per sink, 1X means bank C
  localparam logic [7:0] SINK_MAP_MASK  = 8'h3f;
  localparam logic [7:0] SINK_MAP_RESET = 8'h24;

  localparam logic [2:0] TARGET_FOUR = 3'h4;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
  } bpb_reg_req_t;

  typedef struct packed {
    logic       pwm;
    logic       bus_ctrl;
    logic       linear;
    logic [2:0] target;
  } bpb_sink_t;

  typedef struct packed {
    logic [NUM_BANKS-1:0][7:0] pwm_map;
    logic [NUM_BANKS-1:0][7:0] bri_cfg;
    logic [7:0]                sink_map;
    logic [1:0]                sync1;
    logic [1:0]                sync2;
    logic [7:0]                rdata;
    bpb_sink_t [NUM_BANKS-1:0] sink;
  } bpb_state_t;

endpackage

// ### logic/bpb_bank_cfg.sv
`timescale 1ns/1ps
module bpb_bank_cfg (
  input  wire logic                        CLOCK_I,
  input  wire logic                        SYS_RST_I,
  input  wire bpb_pkg::bpb_reg_req_t       REG_REQ_I,
  output logic [7:0]                       REG_RDATA_O,
  input  wire logic                        PWM_ONE_I,
  input  wire logic                        PWM_TWO_I,
  input  wire logic [2:0]                  ZONE_I,
  output bpb_pkg::bpb_sink_t [2:0]         SINK_O
);

  bpb_pkg::bpb_state_t state_reg;
  bpb_pkg::bpb_state_t state_next;
  logic [2:0]          bank_pwm;
  logic [2:0]          bank_zone_en;
  logic [2:0]          bank_in;
  logic [2:0][2:0]     bank_tgt;
  logic                zone_ok;

  assign REG_RDATA_O = state_reg.rdata;
  assign SINK_O      = state_reg.sink;
  assign zone_ok     = ZONE_I < 3'(bpb_pkg::NUM_ZONES);

  // Per-bank gating from registered state and the live zone input
  always_comb begin
    for (int b = 0; b < bpb_pkg::NUM_BANKS; b++) begin
      logic [7:0] pm;
      logic [7:0] bc;
      pm = state_reg.pwm_map[b];
      bc = state_reg.bri_cfg[b];
      // Only the second stage is looked at
      bank_in[b] = pm[bpb_pkg::PWM_SEL_BIT] ? state_reg.sync2[1]
                                            : state_reg.sync2[0];
      bank_zone_en[b] = zone_ok &&
                        pm[bpb_pkg::PWM_ZONE_LSB + 32'(ZONE_I)];
      // Disabled zone runs the bank at full duty
      if (bank_zone_en[b]) begin
        bank_pwm[b] = pm[bpb_pkg::PWM_POL_BIT] ? bank_in[b]
                                               : !bank_in[b];
      end else begin
        bank_pwm[b] = 1'b1;
      end
      if (bc[bpb_pkg::BRI_BUS_BIT]) begin
        bank_tgt[b] = bc[bpb_pkg::BRI_PTR_MSB] ? bpb_pkg::TARGET_FOUR
                      : {1'b0, bc[bpb_pkg::BRI_PTR_LSB +: 2]};
      end else begin
        // Ambient path follows the live zone, pointer ignored
        bank_tgt[b] = zone_ok ? ZONE_I : bpb_pkg::TARGET_FOUR;
      end
    end
  end

  always_comb begin
    logic [1:0] sel;
    logic [7:0] wd;
    sel = 2'h0;
    wd = REG_REQ_I.wdata;
    state_next = state_reg;
    state_next.sync1 = {PWM_TWO_I, PWM_ONE_I};
    state_next.sync2 = state_reg.sync1;
    if (REG_REQ_I.wr) begin
      unique case (REG_REQ_I.addr)
        bpb_pkg::OFF_PWM_MAP_A:
          state_next.pwm_map[0] = wd & bpb_pkg::PWM_MAP_MASK;
        bpb_pkg::OFF_PWM_MAP_B:
          state_next.pwm_map[1] = wd & bpb_pkg::PWM_MAP_MASK;
        bpb_pkg::OFF_PWM_MAP_C:
          state_next.pwm_map[2] = wd & bpb_pkg::PWM_MAP_MASK;
        bpb_pkg::OFF_BRI_CFG_A:
          state_next.bri_cfg[0] = wd & bpb_pkg::BRI_CFG_MASK;
        bpb_pkg::OFF_BRI_CFG_B:
          state_next.bri_cfg[1] = wd & bpb_pkg::BRI_CFG_MASK;
        bpb_pkg::OFF_BRI_CFG_C:
          state_next.bri_cfg[2] = wd & bpb_pkg::BRI_CFG_MASK;
        bpb_pkg::OFF_SINK_MAP:
          state_next.sink_map = wd & bpb_pkg::SINK_MAP_MASK;
        default: ;
      endcase
    end
    // Read data lags the address by one clock; unmapped reads zero
    unique case (REG_REQ_I.addr)
      bpb_pkg::OFF_PWM_MAP_A: state_next.rdata = state_reg.pwm_map[0];
      bpb_pkg::OFF_PWM_MAP_B: state_next.rdata = state_reg.pwm_map[1];
      bpb_pkg::OFF_PWM_MAP_C: state_next.rdata = state_reg.pwm_map[2];
      bpb_pkg::OFF_BRI_CFG_A: state_next.rdata = state_reg.bri_cfg[0];
      bpb_pkg::OFF_BRI_CFG_B: state_next.rdata = state_reg.bri_cfg[1];
      bpb_pkg::OFF_BRI_CFG_C: state_next.rdata = state_reg.bri_cfg[2];
      bpb_pkg::OFF_SINK_MAP:  state_next.rdata = state_reg.sink_map;
      default:                state_next.rdata = 8'h00;
    endcase
    for (int s = 0; s < bpb_pkg::NUM_BANKS; s++) begin
      sel = state_reg.sink_map[2*s +: 2];
      if (sel[1]) begin
        sel = 2'h2;
      end
      state_next.sink[s].pwm      = bank_pwm[sel];
      state_next.sink[s].bus_ctrl =
        state_reg.bri_cfg[sel][bpb_pkg::BRI_BUS_BIT];
      state_next.sink[s].linear   =
        state_reg.bri_cfg[sel][bpb_pkg::BRI_LIN_BIT];
      state_next.sink[s].target   = bank_tgt[sel];
    end
    if (SYS_RST_I) begin
      state_next = '0;
      for (int b = 0; b < bpb_pkg::NUM_BANKS; b++) begin
        state_next.pwm_map[b] = bpb_pkg::PWM_MAP_RESET;
        state_next.bri_cfg[b] = bpb_pkg::BRI_CFG_RESET;
      end
      state_next.sink_map = bpb_pkg::SINK_MAP_RESET;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    state_reg <= state_next;
  end

  // Checks
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  a_sel_one_b: assert property (
    !state_reg.pwm_map[1][0] && state_reg.pwm_map[1][1] && bank_zone_en[1]
    |-> bank_pwm[1] == $past(PWM_ONE_I, 2))
    else $error("bank B not following PWM input one");

  a_sel_two_c: assert property (
    state_reg.pwm_map[2][0] && state_reg.pwm_map[2][1] && bank_zone_en[2]
    |-> bank_pwm[2] == $past(PWM_TWO_I, 2))
    else $error("bank C not following PWM input two");

  a_pol_low: assert property (
    state_reg.pwm_map[0][1:0] == 2'h0 && bank_zone_en[0]
    |-> bank_pwm[0] == !$past(PWM_ONE_I, 2))
    else $error("active low polarity not inverted");

  a_zone_off: assert property (
    zone_ok && !state_reg.pwm_map[1][bpb_pkg::PWM_ZONE_LSB + 32'(ZONE_I)]
    |-> bank_pwm[1])
    else $error("PWM applied in disabled zone");

  a_mode_sink: assert property (
    state_reg.sink_map[1:0] == 2'h0
    |=> SINK_O[0].bus_ctrl == $past(state_reg.bri_cfg[0][0]) &&
        SINK_O[0].linear == $past(state_reg.bri_cfg[0][1]))
    else $error("sink one mode differs from bank A");

  a_ptr_four: assert property (
    state_reg.bri_cfg[1][0] && state_reg.bri_cfg[1][4]
    |-> bank_tgt[1] == 3'h4)
    else $error("pointer 1XX did not pick target four");

  a_ambient_zone: assert property (
    !state_reg.bri_cfg[2][0] && zone_ok |-> bank_tgt[2] == ZONE_I)
    else $error("pointer used under ambient control");

  a_write_bri: assert property (
    REG_REQ_I.wr && REG_REQ_I.addr == bpb_pkg::OFF_BRI_CFG_B
    |=> state_reg.bri_cfg[1] ==
        ($past(REG_REQ_I.wdata) & bpb_pkg::BRI_CFG_MASK))
    else $error("bank B brightness write lost");

  a_write_pwm: assert property (
    REG_REQ_I.wr && REG_REQ_I.addr == bpb_pkg::OFF_PWM_MAP_C
    |=> state_reg.pwm_map[2] ==
        ($past(REG_REQ_I.wdata) & bpb_pkg::PWM_MAP_MASK))
    else $error("bank C PWM write lost");

  a_read_back: assert property (
    !REG_REQ_I.wr && REG_REQ_I.addr == bpb_pkg::OFF_PWM_MAP_A
    |=> REG_RDATA_O == $past(state_reg.pwm_map[0]) && !REG_RDATA_O[7])
    else $error("bank A PWM read back wrong");

  a_sink_map: assert property (
    state_reg.sink_map[5:4] == 2'h1 |=> SINK_O[2].pwm == $past(bank_pwm[1]))
    else $error("sink three not following bank B");

  a_unmapped: assert property (
    REG_REQ_I.addr == 8'h17 |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");

  // Reset edges clear the synchroniser to zero, so those cycles are skipped
  a_sync_two: assert property (
    !$past(SYS_RST_I) && !$past(SYS_RST_I, 2)
    |-> state_reg.sync2[0] == $past(PWM_ONE_I, 2) &&
        state_reg.sync2[1] == $past(PWM_TWO_I, 2))
    else $error("PWM synchroniser depth wrong");

  a_reset_cfg: assert property (
    $past(SYS_RST_I)
    |-> state_reg.bri_cfg == {3{bpb_pkg::BRI_CFG_RESET}} &&
        state_reg.pwm_map == {3{bpb_pkg::PWM_MAP_RESET}} &&
        state_reg.sink_map == bpb_pkg::SINK_MAP_RESET)
    else $error("configuration not at reset value after reset");

  a_lin_sink: assert property (
    state_reg.sink_map[3:2] == 2'h1
    |=> SINK_O[1].linear == $past(state_reg.bri_cfg[1][1]))
    else $error("sink two mapping mode differs from bank B");

  a_ptr_low: assert property (
    state_reg.bri_cfg[0][0] && !state_reg.bri_cfg[0][4]
    |-> bank_tgt[0] == {1'b0, state_reg.bri_cfg[0][3:2]})
    else $error("pointer 0XX did not pick its target");

  a_zone_none: assert property (
    !zone_ok |-> bank_pwm == 3'h7)
    else $error("PWM applied outside the five zones");

  a_sink_one_c: assert property (
    state_reg.sink_map[1] |=> SINK_O[0].pwm == $past(bank_pwm[2]))
    else $error("sink one not following bank C");

  a_unused_zero: assert property (
    state_reg.pwm_map[0][7] == 1'b0 && state_reg.bri_cfg[2][7:5] == 3'h0 &&
    state_reg.sink_map[7:6] == 2'h0)
    else $error("unused register bits not zero");

  c_pwm_two:   cover property (state_reg.pwm_map[1][0] && bank_zone_en[1]);
  c_ambient:   cover property (!state_reg.bri_cfg[0][0] && zone_ok);
  c_remap:     cover property (state_reg.sink_map[1:0] == 2'h2);
  c_zone_none: cover property (!zone_ok && state_reg.pwm_map[2][1]);
  c_pol_low:   cover property (!state_reg.pwm_map[2][1] && bank_zone_en[2]);

endmodule

// ### tb/bpb_pwm_src.sv
`timescale 1ns/1ps
module bpb_pwm_src (
  input  wire logic       clk_i,
  input  wire logic [1:0] level_i,
  output logic            pwm_one_o,
  output logic            pwm_two_o
);
  // Levels move on the falling edge, half a period from the sampling edge
  initial begin
    pwm_one_o = 1'b0;
    pwm_two_o = 1'b0;
  end
  always @(negedge clk_i) begin
    pwm_one_o <= level_i[0];
    pwm_two_o <= level_i[1];
  end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic                     clk  = 1'b0;
  logic                     rst  = 1'b1;
  bpb_pkg::bpb_reg_req_t    req  = '0;
  logic [7:0]               rdata;
  logic [1:0]               lvl  = 2'b00;
  logic                     p1;
  logic                     p2;
  logic [2:0]               zone = 3'h0;
  bpb_pkg::bpb_sink_t [2:0] sink;
  int                       fail_count  = 0;
  int                       checks_done = 0;
  logic [7:0]               m [0:255];
  logic [7:0]               addrs [0:8] = '{8'h10, 8'h11, 8'h13, 8'h14,
                                            8'h15, 8'h16, 8'h17, 8'h18, 8'h1a};

  always #4 clk = ~clk;

  bpb_bank_cfg i_bpb_bank_cfg (.CLOCK_I(clk), .SYS_RST_I(rst),
    .REG_REQ_I(req), .REG_RDATA_O(rdata), .PWM_ONE_I(p1),
    .PWM_TWO_I(p2), .ZONE_I(zone), .SINK_O(sink));
  bpb_pwm_src i_bpb_pwm_src (.clk_i(clk), .level_i(lvl),
    .pwm_one_o(p1), .pwm_two_o(p2));

  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      8'h10: mask = 8'h3f;
      8'h13, 8'h14, 8'h15: mask = 8'h7f;
      8'h16, 8'h18, 8'h1a: mask = 8'h1f;
      default: mask = 8'h00;
    endcase
  endfunction

  // Expected sink outputs from the model registers and current inputs
  function automatic logic [17:0] model_sink();
    logic [17:0] e;
    logic [7:0]  pm;
    logic [7:0]  bc;
    logic [1:0]  b;
    logic        lv;
    e = '0;
    for (int s = 0; s < 3; s++) begin
      b = m[8'h10][2*s+:2];
      if (b[1]) b = 2'd2;
      pm = m[8'h13 + b];
      bc = m[8'h16 + 2*b];
      lv = (pm[0] ? lvl[1] : lvl[0]) ~^ pm[1];
      e[6*s+5] = (zone < 5 && pm[2+zone]) ? lv : 1'b1;
      e[6*s+4] = bc[0];
      e[6*s+3] = bc[1];
      e[6*s+:3] = bc[0] ? (bc[4] ? 3'h4 : {1'b0, bc[3:2]})
                        : (zone > 4 ? 3'h4 : zone);
    end
    return e;
  endfunction

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Write strobe stays high between back-to-back calls
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{addr: a, wdata: d, wr: 1'b1};
    m[a] = d & mask(a);
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a);
    req = '{addr: a, wdata: 8'h00, wr: 1'b0};
    @(negedge clk);
    check({10'h000, rdata}, {10'h000, m[a]});
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(32'h922bee2b));
    foreach (m[a]) begin
      case (mask(8'(a)))
        8'h3f: m[a] = 8'h24;
        8'h7f: m[a] = 8'h02;
        8'h1f: m[a] = 8'h11;
        default: m[a] = 8'h00;
      endcase
    end
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    check(sink, model_sink());
    foreach (addrs[i]) rd(addrs[i]);
    // Random config, zone and PWM levels; PWM path needs four edges
    for (int i = 0; i < 80; i++) begin
      wr(addrs[$urandom_range(8)], 8'($urandom));
      wr(addrs[$urandom_range(8)], 8'($urandom));
      zone = 3'($urandom_range(7));
      // Non-blocking so the partner always takes it a falling edge later
      lvl <= 2'($urandom);
      rd(addrs[$urandom_range(8)]);
      repeat (4) @(negedge clk);
      check(sink, model_sink());
    end
    final_report();
  end
endmodule
